// ==== rtl/sdsp_top.sv ====
// Serial slave port of a multiple switch detection interface, with timers.
// Assumes the host drives the shift clock and chip select; switch and
// thermal levels arrive as asynchronous pins from the comparators.
//
// Contract
// - Wetting pulse lasts nominally 16 ms.
// - Sleep scan every nominally 200 us.
// - Calibrated scan timer within 10 percent.
// - Calibrated interrupt timer within 10 percent.
// - Command in, status out while selected.
// - Select fall enables output, captures state.
// - Select rise tri-states serial output.
// - Select rise releases interrupt unless new changes.
// - Select rise commits received command.
// - Select fall wakes sleeping device; data suspect.
// - Input bit sampled on falling clock.
// - Output bit shifted on rising clock.
// - Deselected: ignore clock and input, tri-state.
// - High input bit sets command bit.
// - Closed switch reads one, open zero.
// - First rising edge presents status MSB.
// - Both words travel MSB first, FIFO.
// - Every reply carries switches and both flags.
`timescale 1ns/10ps
module sdsp_top #(
  parameter logic [23:0] WET_CYC     = sdsp_pkg::WET_CYCLES,
  parameter logic [23:0] SCAN_CYC    = sdsp_pkg::SCAN_CYCLES,
  parameter logic [23:0] INT_TMR_CYC = sdsp_pkg::INT_TMR_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  input  wire logic                          link_sclk,
  input  wire logic                          cs_n,
  input  wire logic                          si,
  output logic                               so_o,
  output logic                               so_oe,
  output logic                               int_n_o,
  output logic                               int_n_oe,
  input  wire logic [sdsp_pkg::SW_COUNT-1:0] sw_closed,
  input  wire logic                          thermal_in,
  input  wire logic                          sleep_mode,
  output sdsp_pkg::sdsp_cmd_t                cmd,
  output logic                               wake_req,
  output logic                               frame_suspect,
  output logic                               wet_on,
  output logic                               scan_strobe,
  output logic                               int_tmr_expire
);

  // Synchronised pin levels
  logic [sdsp_pkg::SYNC_W-1:0]   sync_lvl;
  logic                          cs_q;        // Accepted chip select level
  logic                          therm_q;     // Accepted thermal level
  logic [sdsp_pkg::SW_COUNT-1:0] sw_now;      // Accepted switch levels

  // System-domain state
  logic                          cs_prev_reg;      // Chip select one cycle ago
  logic [sdsp_pkg::SW_COUNT-1:0] sw_prev_reg;      // Switches one cycle ago
  logic                          int_pend_reg;     // Interrupt line asserted
  logic                          int_pend_next;
  logic                          chg_low_reg;      // Change seen while selected
  sdsp_pkg::sdsp_status_t        snap_reg;         // Frozen status for the frame
  logic [23:0]                   cmd_word_reg;     // Last committed command
  logic                          cmd_valid_reg;    // Commit pulse
  logic                          wake_reg;         // Wake pulse
  logic                          suspect_reg;      // Frame started while asleep

  // Link-domain state
  logic [23:0]                   chain_reg;        // Shift chain, MSB leaves first
  logic [sdsp_pkg::CNT_W-1:0]    bit_cnt_reg;      // Bits received, saturating
  logic                          seen_fall_reg;    // A falling edge this frame
  logic                          so_bit_reg;       // Bit on the serial output

  // Timer outputs
  logic wet_active;
  logic scan_tick;
  logic int_tick;

  // Pins pass three stages before use. Select enters inverted: the stages reset
  // to zero, which then reads as an idle pin, so no false select edge follows reset.
  sdsp_sync #(
    .W (sdsp_pkg::SYNC_W)
  ) u_sync (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pin_in    ({~cs_n, thermal_in, sw_closed}),
    .level_out (sync_lvl)
  );

  assign cs_q    = ~sync_lvl[sdsp_pkg::SYNC_CS];
  assign therm_q = sync_lvl[sdsp_pkg::SYNC_THERM];
  assign sw_now  = sync_lvl[sdsp_pkg::SW_COUNT-1:0];

  // Edge and event decode in the system domain
  wire cs_fall   = cs_prev_reg & ~cs_q;
  wire cs_rise   = ~cs_prev_reg & cs_q;
  wire sw_change = (sw_now != sw_prev_reg);
  wire sw_closing = |(sw_now & ~sw_prev_reg);
  wire frame_ok  = (bit_cnt_reg == sdsp_pkg::FRAME_FULL);

  // Interrupt line: a change sets it, select rise clears it unless chg_low_reg is set, set wins
  always_comb begin
    int_pend_next = int_pend_reg;
    if (cs_rise) begin
      int_pend_next = chg_low_reg;
    end
    if (sw_change) begin
      int_pend_next = 1'b1;
    end
  end

  // Edge history and interrupt state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_prev_reg  <= 1'b1;
      sw_prev_reg  <= '0;
      int_pend_reg <= 1'b0;
    end else begin
      cs_prev_reg  <= cs_q;
      sw_prev_reg  <= sw_now;
      int_pend_reg <= int_pend_next;
    end
  end

  // Remember changes that land while selected; a new frame starts clean
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chg_low_reg <= 1'b0;
    end else if (cs_fall) begin
      chg_low_reg <= sw_change;
    end else if (!cs_q && sw_change) begin
      chg_low_reg <= 1'b1;
    end else if (cs_rise) begin
      chg_low_reg <= 1'b0;
    end
  end

  // Freeze interrupt, thermal and switch state for the outgoing word.
  // The link side reads this word only between its own clock edges, well
  // after the freeze, so it crosses as a held word with no per-bit sync.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      snap_reg <= '0;
    end else if (cs_fall) begin
      snap_reg.int_flag     <= int_pend_reg;
      snap_reg.thermal_flag <= therm_q;
      snap_reg.closed       <= sw_now;
    end
  end

  // Commit the command once select rises; short frames are dropped
  // because the host is bound to send the full word first.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_word_reg  <= '0;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= cs_rise & frame_ok;
      if (cs_rise && frame_ok) begin
        cmd_word_reg <= chain_reg;
      end
    end
  end

  // Wake on select fall or interrupt timer while asleep; flag the frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_reg    <= 1'b0;
      suspect_reg <= 1'b0;
    end else begin
      wake_reg <= (cs_fall & sleep_mode) | int_tick;
      if (cs_fall) begin
        suspect_reg <= sleep_mode;
      end
    end
  end

  // Link side: deselect clears frame state at once, so any clocking
  // while deselected does nothing and the next frame starts fresh.
  wire frame_rst = cs_n | ~rstn;

  // Bits before the first falling edge come from the frozen status
  wire [23:0] chain_base = seen_fall_reg ? chain_reg : snap_reg;

  // Falling edge: sample the input into the chain, count bits
  always_ff @(negedge link_sclk or negedge rstn) begin
    if (!rstn) begin
      chain_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (!cs_n) begin
      chain_reg <= {chain_base[22:0], si};
      if (!seen_fall_reg) begin
        bit_cnt_reg <= sdsp_pkg::FIRST_BIT;
      end else if (bit_cnt_reg != sdsp_pkg::FRAME_FULL) begin
        bit_cnt_reg <= bit_cnt_reg + sdsp_pkg::FIRST_BIT;
      end
    end
  end

  // Marks that the chain now holds the shifted word
  always_ff @(negedge link_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      seen_fall_reg <= 1'b0;
    end else begin
      seen_fall_reg <= 1'b1;
    end
  end

  // Rising edge: present the next bit, status MSB on the first edge
  always_ff @(posedge link_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      so_bit_reg <= 1'b0;
    end else begin
      so_bit_reg <= chain_base[sdsp_pkg::STAT_MSB];
    end
  end

  // Driver follows select directly so it opens and closes within the frame
  assign so_oe = ~cs_n;
  assign so_o  = so_bit_reg;

  // Open-drain interrupt: pulls low while pending
  assign int_n_o  = 1'b0;
  assign int_n_oe = int_pend_reg;

  // Wetting pulse, retriggered by each closing contact
  sdsp_timer #(
    .PERIOD   (WET_CYC),
    .PERIODIC (1'b0)
  ) u_wet (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (1'b1),
    .start   (sw_closing),
    .active  (wet_active),
    .tick    ()
  );

  // Sleep scan, free-running while asleep; the clock is crystal based,
  // so the calibrated period is exact rather than merely within tolerance
  sdsp_timer #(
    .PERIOD   (SCAN_CYC),
    .PERIODIC (1'b1)
  ) u_scan (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (sleep_mode),
    .start   (1'b0),
    .active  (),
    .tick    (scan_tick)
  );

  // Sleep interrupt timer, also exact by construction
  sdsp_timer #(
    .PERIOD   (INT_TMR_CYC),
    .PERIODIC (1'b1)
  ) u_int_tmr (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (sleep_mode),
    .start   (1'b0),
    .active  (),
    .tick    (int_tick)
  );

  assign cmd.valid      = cmd_valid_reg;
  assign cmd.word       = cmd_word_reg;
  assign wake_req       = wake_reg;
  assign frame_suspect  = suspect_reg;
  assign wet_on         = wet_active;
  assign scan_strobe    = scan_tick;
  assign int_tmr_expire = int_tick;

  // Helper counters for timing checks
  logic [23:0] wet_len_reg;   // Cycles the wetting pulse has lasted
  logic [23:0] scan_gap_reg;  // Cycles since last scan tick
  logic [23:0] int_gap_reg;   // Cycles since last interrupt timer tick

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wet_len_reg  <= '0;
      scan_gap_reg <= '0;
      int_gap_reg  <= '0;
    end else begin
      wet_len_reg  <= (sw_closing || !wet_active) ? 24'h000000 : wet_len_reg + 24'h000001;
      scan_gap_reg <= (scan_tick || !sleep_mode) ? 24'h000000 : scan_gap_reg + 24'h000001;
      int_gap_reg  <= (int_tick || !sleep_mode) ? 24'h000000 : int_gap_reg + 24'h000001;
    end
  end

  // Tolerance bounds for the calibrated timers
  wire [31:0] scan_lo = (32'(SCAN_CYC) * (100 - sdsp_pkg::CAL_TOL_PCT)) / 100;
  wire [31:0] scan_hi = (32'(SCAN_CYC) * (100 + sdsp_pkg::CAL_TOL_PCT)) / 100;
  wire [31:0] int_lo  = (32'(INT_TMR_CYC) * (100 - sdsp_pkg::CAL_TOL_PCT)) / 100;
  wire [31:0] int_hi  = (32'(INT_TMR_CYC) * (100 + sdsp_pkg::CAL_TOL_PCT)) / 100;

  chk_so_on_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_fall && !cs_n |-> so_oe)
    else $error("serial output not enabled after select fall");

  chk_so_off_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && cs_n |-> !so_oe && !so_o)
    else $error("serial output still driven or not cleared after select rise");

  chk_snap_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_fall |=> (snap_reg.closed == $past(sw_now)) && (snap_reg.int_flag == $past(int_pend_reg)))
    else $error("status not captured at select fall");

  chk_int_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && !chg_low_reg && !sw_change |=> !int_pend_reg [*2] or (sw_change))
    else $error("interrupt not released at select rise");

  chk_int_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && chg_low_reg |=> int_pend_reg)
    else $error("interrupt released despite change while selected");

  chk_cmd_commit: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && frame_ok |=> cmd_valid_reg && (cmd_word_reg == $past(chain_reg)) ##1 !cmd_valid_reg)
    else $error("command not committed at select rise");

  chk_wake_cs: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_fall && sleep_mode |=> wake_reg && suspect_reg)
    else $error("select fall did not wake sleeping device");

  chk_wet_length: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(wet_active) |-> $past(wet_len_reg) == WET_CYC - 24'h000001)
    else $error("wetting pulse length wrong");

  chk_scan_period: assert property (@(posedge clk_sys) disable iff (!rstn)
    scan_tick && $past(sleep_mode) && (scan_gap_reg != 24'h000000)
      |-> (32'(scan_gap_reg) + 1 >= scan_lo) && (32'(scan_gap_reg) + 1 <= scan_hi))
    else $error("scan period outside tolerance");

  chk_int_period: assert property (@(posedge clk_sys) disable iff (!rstn)
    int_tick && $past(sleep_mode) && (int_gap_reg != 24'h000000)
      |-> (32'(int_gap_reg) + 1 >= int_lo) && (32'(int_gap_reg) + 1 <= int_hi))
    else $error("interrupt timer period outside tolerance");

  chk_first_bit: assert property (@(posedge link_sclk) disable iff (frame_rst)
    !seen_fall_reg |=> so_bit_reg == snap_reg[sdsp_pkg::STAT_MSB])
    else $error("first bit is not status MSB");

endmodule

// ==== rtl/sdsp_pkg.sv ====
// Shared constants and carriers for the switch detect serial port.
// Assumes a 125 MHz system clock; the link clock comes from the host.
package sdsp_pkg;

  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Frame geometry: 24 bits each way, 22 switch inputs
  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned SW_COUNT     = 22;
  localparam int unsigned CNT_W        = 5;
  localparam logic [4:0]  FRAME_FULL   = 5'h18;
  localparam logic [4:0]  FIRST_BIT    = 5'h01;
  localparam int unsigned STAT_MSB     = 23;

  // Synchroniser covers chip select, thermal flag and all switches
  localparam int unsigned SYNC_W       = 24;
  localparam int unsigned SYNC_CS      = 23;
  localparam int unsigned SYNC_THERM   = 22;

  // Timer widths and times as printed
  localparam int unsigned TMR_W        = 24;
  localparam int unsigned WET_PULSE_MS = 16;
  localparam int unsigned SCAN_US      = 200;
  localparam int unsigned INT_TMR_US   = 32000;
  localparam int unsigned CAL_TOL_PCT  = 10;

  // Cycle counts derived from the times
  localparam logic [23:0] WET_CYCLES =
    24'((WET_PULSE_MS * 1000 * 1000) / CLK_PERIOD_NS);
  localparam logic [23:0] SCAN_CYCLES =
    24'((SCAN_US * 1000) / CLK_PERIOD_NS);
  localparam logic [23:0] INT_TMR_CYCLES =
    24'((INT_TMR_US * 1000) / CLK_PERIOD_NS);

  // Status word sent back in every frame, MSB first
  typedef struct packed {
    logic                int_flag;      // Interrupt line state at frame start
    logic                thermal_flag;  // Thermal limit reached
    logic [SW_COUNT-1:0] closed;        // One per switch, 1 = closed
  } sdsp_status_t;

  // Command word handed to the rest of the device
  typedef struct packed {
    logic                  valid;       // One-cycle commit pulse
    logic [FRAME_BITS-1:0] word;        // Command bits, MSB first on the wire
  } sdsp_cmd_t;

endpackage

// ==== rtl/sdsp_sync.sv ====
// Three-stage input synchroniser, one lane per bit.
// Assumes asynchronous pins; a change counts once stages two and three agree.
`timescale 1ns/10ps
module sdsp_sync #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  // One lane per bit; stage one feeds only stage two
  for (genvar i = 0; i < W; i++) begin : g_lane
    logic s1_reg;   // Metastability catcher
    logic s2_reg;   // Second stage
    logic s3_reg;   // Third stage
    logic lvl_reg;  // Accepted level

    // Accept a new level only when the last two stages match
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        s1_reg  <= 1'b0;
        s2_reg  <= 1'b0;
        s3_reg  <= 1'b0;
        lvl_reg <= 1'b0;
      end else begin
        s1_reg <= pin_in[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          lvl_reg <= s3_reg;
        end
      end
    end

    assign level_out[i] = lvl_reg;
  end

endmodule

// ==== rtl/sdsp_timer.sv ====
// Down-counting timer, one-shot or free-running.
// Assumes start and run come from logic on clk_sys.
`timescale 1ns/10ps
module sdsp_timer #(
  parameter logic [23:0] PERIOD   = 24'h000010,
  parameter bit          PERIODIC = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic start,
  output logic      active,
  output logic      tick
);

  logic [23:0] cnt_reg;     // Cycles left in this period
  logic        active_reg;  // Timer running
  logic        tick_reg;    // End of period pulse

  // Load on start, or on entering run when free-running
  wire load    = start | (PERIODIC & run & ~active_reg);
  wire at_end  = active_reg & (cnt_reg == 24'h000000);
  wire reload  = PERIODIC & run;

  // Count down; a retrigger restarts the full period
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg    <= 24'h000000;
      active_reg <= 1'b0;
      tick_reg   <= 1'b0;
    end else begin
      tick_reg <= at_end;
      if (load) begin
        cnt_reg    <= PERIOD - 24'h000001;
        active_reg <= 1'b1;
      end else if (PERIODIC && !run) begin
        active_reg <= 1'b0;
      end else if (at_end) begin
        cnt_reg    <= PERIOD - 24'h000001;
        active_reg <= reload;
      end else if (active_reg) begin
        cnt_reg <= cnt_reg - 24'h000001;
      end
    end
  end

  assign active = active_reg;
  assign tick   = tick_reg;

endmodule

// ==== dv/sdsp_host.sv ====
// Host model: serial bus master for the switch detect serial port.
// Assumes go and noise are raised by the bench; the link clock runs only in frames and noise bursts.
`timescale 1ns/10ps
module sdsp_host (
  input  wire logic        go,         // Start one frame
  input  wire logic        noise,      // Clock burst with select high
  input  wire logic [5:0]  nbits,      // Bits in the frame
  input  wire logic [23:0] word,       // Command, MSB first
  input  wire logic        so_o,       // Serial data from the device
  output logic             link_sclk,  // Shift clock, parked low
  output logic             cs_n,       // Chip select
  output logic             si,         // Serial data to the device
  output logic [23:0]      rx,         // Status shifted in
  output logic             done        // Frame finished
);
  initial begin
    link_sclk = 1'b0;
    cs_n      = 1'b1;
    si        = 1'b0;
    rx        = 24'h000000;
    done      = 1'b0;
  end

  // One frame; the clock is low at both select edges
  always @(posedge go) begin
    #37.3 cs_n = 1'b0;
    #200;  // Lead time, so the status snapshot is frozen first
    for (int i = 0; i < nbits; i++) begin
      link_sclk = 1'b1;
      #10 si = word[23 - i];  // MSB first
      #70 link_sclk = 1'b0;
      rx = {rx[22:0], so_o};  // Taken on the falling edge
      #80;
    end
    cs_n = 1'b1;
    si   = ~si;  // A released line must not keep its last value
    #8 done = 1'b1;
    #16 done = 1'b0;
  end

  // Clock and data wiggle while deselected; the device must ignore it
  always @(posedge noise) begin
    repeat (4) begin
      #80 link_sclk = 1'b1;
      si = ~si;
      #80 link_sclk = 1'b0;
    end
  end
endmodule

// ==== dv/sdsp_top_tb.sv ====
// Self-checking bench for the switch detect serial port.
// Assumes sdsp_pkg is compiled first; timers run with shortened counts.
`timescale 1ns/10ps
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); \
  end \
end
module sdsp_top_tb;
  localparam int WET_N  = 200;  // Shortened wetting pulse
  localparam int SCAN_N = 50;   // Shortened scan period
  localparam int INT_N  = 100;  // Shortened interrupt timer

  logic                 clk_sys = 1'b0;   // System clock
  logic                 rstn;             // Reset, active low
  logic [21:0]          sw_closed;        // Switch levels
  logic                 thermal_in;       // Thermal level
  logic                 sleep_mode;       // Sleep request
  logic                 so_o;             // Serial out value
  logic                 so_oe;            // Serial out enable
  logic                 int_n_o;          // Interrupt drive value
  logic                 int_n_oe;         // Interrupt drive enable
  sdsp_pkg::sdsp_cmd_t  cmd;              // Committed command
  logic                 wake_req;         // Wake pulse
  logic                 frame_suspect;    // Frame began in sleep
  logic                 wet_on;           // Wetting pulse
  logic                 scan_strobe;      // Scan tick
  logic                 int_tmr_expire;   // Interrupt timer tick
  logic                 link_sclk;        // Host shift clock
  logic                 cs_n;             // Host chip select
  logic                 si;               // Host serial data
  logic                 h_go;             // Frame start
  logic                 h_noise;          // Deselected burst start
  logic [5:0]           h_nbits;          // Frame length
  logic [23:0]          h_word;           // Command to send
  logic [23:0]          h_rx;             // Status received
  logic                 h_done;           // Frame end
  logic [23:0]          cmd_q[$];         // Expected commits
  logic [23:0]          stat_q[$];        // Expected status words
  logic [23:0]          w;                // Current command
  logic [23:0]          exp_w;            // Popped command
  sdsp_pkg::sdsp_status_t exp_s;          // Popped status
  logic [21:0]          sw;               // Current switch pattern
  int                   fails = 0;
  int                   samples_checked = 0;
  int                   n;                // Measured cycle count
  integer               seed = 32'ha134;  // Fixed seed

  // Open-drain interrupt line with its pull-up
  wire       int_line = int_n_oe ? int_n_o : 1'b1;
  wire [1:0] pulses   = {int_tmr_expire, scan_strobe};

  always #4 clk_sys = ~clk_sys;

  sdsp_top #(
    .WET_CYC     (24'h0000C8),
    .SCAN_CYC    (24'h000032),
    .INT_TMR_CYC (24'h000064)
  ) dut_u (
    .clk_sys        (clk_sys),
    .rstn           (rstn),
    .link_sclk      (link_sclk),
    .cs_n           (cs_n),
    .si             (si),
    .so_o           (so_o),
    .so_oe          (so_oe),
    .int_n_o        (int_n_o),
    .int_n_oe       (int_n_oe),
    .sw_closed      (sw_closed),
    .thermal_in     (thermal_in),
    .sleep_mode     (sleep_mode),
    .cmd            (cmd),
    .wake_req       (wake_req),
    .frame_suspect  (frame_suspect),
    .wet_on         (wet_on),
    .scan_strobe    (scan_strobe),
    .int_tmr_expire (int_tmr_expire)
  );

  sdsp_host host_u (
    .go        (h_go),
    .noise     (h_noise),
    .nbits     (h_nbits),
    .word      (h_word),
    .so_o      (so_o),
    .link_sclk (link_sclk),
    .cs_n      (cs_n),
    .si        (si),
    .rx        (h_rx),
    .done      (h_done)
  );

  // Commits are matched with the oldest note; a commit without one is wrong
  always @(negedge clk_sys) begin
    if (cmd.valid === 1'b1) begin
      if (cmd_q.size() == 0) begin
        `CHK(cmd.valid, 1'b0)
      end else begin
        exp_w = cmd_q.pop_front();
        `CHK(cmd.word, exp_w)
      end
    end
  end

  // Status of each full frame against its note; output released after
  always @(posedge h_done) begin
    if (stat_q.size() != 0) begin
      exp_s = stat_q.pop_front();
      `CHK(h_rx, exp_s)
    end
    `CHK(so_oe, 1'b0)
  end

  // Driver enabled as soon as the device is selected
  always @(negedge cs_n) begin
    #4 `CHK(so_oe, 1'b1)
  end

  // One frame; full frames note their commit and status
  task automatic frame(input logic [5:0] nb, input logic [23:0] cw, input logic [23:0] st);
    if (nb == 6'h18) begin
      cmd_q.push_back(cw);
      stat_q.push_back(st);
    end
    h_nbits = nb;
    h_word  = cw;
    h_go    = 1'b1;
    @(posedge h_done);
    h_go = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
  endtask

  // Cycles from one pulse of a strobe to its next pulse
  task automatic gap(input int k, output int c);
    c = 0;
    while (pulses[k] !== 1'b1 && c < 300) begin
      @(posedge clk_sys);
      #1 c++;
    end
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (pulses[k] !== 1'b1 && c < 300);
  endtask

  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn       = 1'b0;
    sleep_mode = 1'b0;
    sw_closed  = 22'h000000;
    thermal_in = 1'b0;
    h_go       = 1'b0;
    h_noise    = 1'b0;
    h_nbits    = 6'h00;
    h_word     = 24'h000000;
    repeat (8) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 w = 24'($random(seed));
    frame(6'h18, w, 24'h000000);
    // Switches close and the thermal flag rises
    sw         = 22'($random(seed)) | 22'h000001;
    sw_closed  = sw;
    thermal_in = 1'b1;
    n = 0;
    while (wet_on !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    n = 0;
    while (wet_on === 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(n, WET_N)
    w = 24'($random(seed));
    frame(6'h18, w, {2'h3, sw});
    `CHK(int_line, 1'b1)
    // A switch changes while selected: interrupt must stay asserted
    w = 24'($random(seed));
    fork
      frame(6'h18, w, {2'h1, sw});
      begin
        repeat (200) @(posedge clk_sys);
        #1 sw = sw ^ 22'h000002;
        sw_closed = sw;
      end
    join
    `CHK(int_line, 1'b0)
    w = 24'($random(seed));
    frame(6'h18, w, {2'h3, sw});
    `CHK(int_line, 1'b1)
    // Short frame and deselected noise commit nothing
    frame(6'h17, 24'($random(seed)), 24'h000000);
    h_noise = 1'b1;
    repeat (200) @(posedge clk_sys);
    #1 h_noise = 1'b0;
    w = 24'($random(seed));
    frame(6'h18, w, {2'h1, sw});
    // Sleep timers, then a frame that starts in sleep
    sleep_mode = 1'b1;
    gap(0, n);
    `CHK(n, SCAN_N)
    gap(1, n);
    `CHK(n, INT_N)
    @(posedge clk_sys);
    #1 `CHK(wake_req, 1'b1)
    w = 24'($random(seed));
    frame(6'h18, w, {2'h1, sw});
    `CHK(frame_suspect, 1'b1)
    sleep_mode = 1'b0;
    w = 24'($random(seed));
    frame(6'h18, w, {2'h1, sw});
    `CHK(frame_suspect, 1'b0)
    // Every noted commit and status word must have been matched by now
    `CHK(cmd_q.size(), 0)
    `CHK(stat_q.size(), 0)
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
endmodule
